// File: hdl/memory_block_defs.vh
`ifndef MEMORY_BLOCK_DEFS_VH
`define MEMORY_BLOCK_DEFS_VH

// ----------------------------------------------------------------------------
// Geometry defaults
// ----------------------------------------------------------------------------
`define MB_DATA_W        8
`define MB_ADDR_W        6
`define MB_NUM_GLOBAL    4
`define MB_NUM_DCLK      4
`define MB_IDX_W         2

// ----------------------------------------------------------------------------
// Port mode
// ----------------------------------------------------------------------------
`define MB_MODE_SINGLE   1'b0
`define MB_MODE_SPLIT    1'b1

// ----------------------------------------------------------------------------
// Clock source select codes
// ----------------------------------------------------------------------------
`define MB_CSRC_GLOBAL   2'b00
`define MB_CSRC_DEDIC    2'b01
`define MB_CSRC_LOCAL    2'b10

// ----------------------------------------------------------------------------
// Strobe source select codes
// ----------------------------------------------------------------------------
`define MB_SSRC_LOCAL    1'b0
`define MB_SSRC_GLOBAL   1'b1

// ----------------------------------------------------------------------------
// Register bypass bit positions
// ----------------------------------------------------------------------------
`define MB_BYP_W         6
`define MB_BYP_WDATA     0
`define MB_BYP_RDATA     1
`define MB_BYP_RADDR     2
`define MB_BYP_WADDR     3
`define MB_BYP_WSTB      4
`define MB_BYP_RSTB      5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MB_RST_BIT       1'b0
`define MB_CLR_IDLE      1'b0

`endif

// File: hdl/embedded_memory_block.v
`timescale 1ns/10ps
`default_nettype none
`include "memory_block_defs.vh"

module embedded_memory_block #(
  parameter DATA_W     = `MB_DATA_W,
  parameter ADDR_W     = `MB_ADDR_W,
  parameter NUM_GLOBAL = `MB_NUM_GLOBAL,
  parameter NUM_DCLK   = `MB_NUM_DCLK
) (
  input  wire                   clk,
  input  wire                   resetn,
  // Configuration straps.
  input  wire                   port_mode,
  input  wire [`MB_BYP_W-1:0]   reg_bypass,
  input  wire [NUM_GLOBAL-1:0]  global_from_logic,
  input  wire [1:0]             in_clk_src,
  input  wire [`MB_IDX_W-1:0]   in_clk_idx,
  input  wire [1:0]             out_clk_src,
  input  wire [`MB_IDX_W-1:0]   out_clk_idx,
  input  wire                   wstb_src,
  input  wire [`MB_IDX_W-1:0]   wstb_idx,
  input  wire                   rstb_src,
  input  wire [`MB_IDX_W-1:0]   rstb_idx,
  input  wire                   in_clr_global_en,
  input  wire                   out_clr_global_en,
  input  wire [`MB_IDX_W-1:0]   clr_global_idx,
  // Device pins.
  input  wire [NUM_GLOBAL-1:0]  dedicated_in_pin,
  input  wire [NUM_DCLK-1:0]    dedicated_clk_pin,
  // Fabric logic cell side.
  input  wire [NUM_GLOBAL-1:0]  global_logic_drive,
  input  wire                   in_clk_local,
  input  wire                   out_clk_local,
  input  wire                   in_clk_en,
  input  wire                   out_clk_en,
  input  wire                   in_clr_local,
  input  wire                   out_clr_local,
  input  wire                   write_strobe_local,
  input  wire                   read_strobe_local,
  input  wire [DATA_W-1:0]      write_data,
  input  wire [ADDR_W-1:0]      write_addr,
  input  wire [ADDR_W-1:0]      read_addr,
  output wire [DATA_W-1:0]      read_data,
  output wire [NUM_GLOBAL-1:0]  global_net,
  output wire                   access_conflict
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg  [NUM_GLOBAL-1:0] ded_in_s1_q;
  reg  [NUM_GLOBAL-1:0] ded_in_s2_q;
  reg  [NUM_DCLK-1:0]   dclk_s1_q;
  reg  [NUM_DCLK-1:0]   dclk_s2_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ded_in_s1_q <= {NUM_GLOBAL{`MB_RST_BIT}};
      ded_in_s2_q <= {NUM_GLOBAL{`MB_RST_BIT}};
    end else begin
      ded_in_s1_q <= dedicated_in_pin;
      ded_in_s2_q <= ded_in_s1_q;
    end
  end

  // Dedicated clock pins are sampled like data, so a port clock taken from
  // them acts two cycles after the pin rises.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dclk_s1_q <= {NUM_DCLK{`MB_RST_BIT}};
      dclk_s2_q <= {NUM_DCLK{`MB_RST_BIT}};
    end else begin
      dclk_s1_q <= dedicated_clk_pin;
      dclk_s2_q <= dclk_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Global signal network
  // --------------------------------------------------------------------------
  // Each global is either its dedicated input or a fabric-made signal such as
  // a divided clock or a generated clear.
  genvar g;
  generate
    for (g = 0; g < NUM_GLOBAL; g = g + 1) begin : g_global
      assign global_net[g] = global_from_logic[g] ? global_logic_drive[g]
                                                  : ded_in_s2_q[g];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Clock source selection and edge ticks
  // --------------------------------------------------------------------------
  // The block runs on clk alone; each selected port clock becomes a one-cycle
  // tick on its rising edge. Source clocks must be well below clk / 2.
  reg in_clk_lvl;
  reg out_clk_lvl;

  always @* begin
    case (in_clk_src)
      `MB_CSRC_GLOBAL: in_clk_lvl = global_net[in_clk_idx];
      `MB_CSRC_DEDIC:  in_clk_lvl = dclk_s2_q[in_clk_idx];
      `MB_CSRC_LOCAL:  in_clk_lvl = in_clk_local;
      default:         in_clk_lvl = `MB_RST_BIT;
    endcase
    case (out_clk_src)
      `MB_CSRC_GLOBAL: out_clk_lvl = global_net[out_clk_idx];
      `MB_CSRC_DEDIC:  out_clk_lvl = dclk_s2_q[out_clk_idx];
      `MB_CSRC_LOCAL:  out_clk_lvl = out_clk_local;
      default:         out_clk_lvl = `MB_RST_BIT;
    endcase
  end

  reg  in_clk_prev_q;
  reg  out_clk_prev_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_clk_prev_q  <= `MB_RST_BIT;
      out_clk_prev_q <= `MB_RST_BIT;
    end else begin
      in_clk_prev_q  <= in_clk_lvl;
      out_clk_prev_q <= out_clk_lvl;
    end
  end

  reg  in_tick;
  reg  out_tick;
  reg  in_load;
  reg  out_load;

  // Single-port mode keeps the output register on the input clock.
  // Ticks are combinational so a port acts in the cycle its clock rises.
  always @* begin
    in_tick = in_clk_lvl & ~in_clk_prev_q;
    if (port_mode == `MB_MODE_SPLIT) begin
      out_tick = out_clk_lvl & ~out_clk_prev_q;
    end else begin
      out_tick = in_tick;
    end
    in_load  = in_tick & in_clk_en;
    out_load = out_tick & out_clk_en;
  end

  // --------------------------------------------------------------------------
  // Asynchronous clears
  // --------------------------------------------------------------------------
  // Clear requests are flopped first so a glitch in the select logic can
  // never fire a clear; the flop itself is reset by the chip-wide reset.
  reg  in_clr_q;
  reg  out_clr_q;
  wire clr_global;

  assign clr_global = global_net[clr_global_idx];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_clr_q  <= `MB_CLR_IDLE;
      out_clr_q <= `MB_CLR_IDLE;
    end else begin
      in_clr_q  <= in_clr_local | (in_clr_global_en & clr_global);
      out_clr_q <= out_clr_local | (out_clr_global_en & clr_global);
    end
  end

  wire in_rst_n  = resetn & ~in_clr_q;
  wire out_rst_n = resetn & ~out_clr_q;

  // --------------------------------------------------------------------------
  // Strobe source selection
  // --------------------------------------------------------------------------
  // A global strobe lets one fabric-made pulse gate many blocks at once.
  reg  wstb_raw;
  reg  rstb_raw;

  always @* begin
    case (wstb_src)
      `MB_SSRC_GLOBAL: wstb_raw = global_net[wstb_idx];
      default:         wstb_raw = write_strobe_local;
    endcase
    case (rstb_src)
      `MB_SSRC_GLOBAL: rstb_raw = global_net[rstb_idx];
      default:         rstb_raw = read_strobe_local;
    endcase
  end

  // --------------------------------------------------------------------------
  // Input-side registers
  // --------------------------------------------------------------------------
  reg  [DATA_W-1:0] wdata_q;
  reg  [ADDR_W-1:0] waddr_q;
  reg  [ADDR_W-1:0] raddr_q;
  reg               wstb_q;
  reg               rstb_q;

  always @(posedge clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      wdata_q <= {DATA_W{`MB_RST_BIT}};
      waddr_q <= {ADDR_W{`MB_RST_BIT}};
      raddr_q <= {ADDR_W{`MB_RST_BIT}};
      wstb_q  <= `MB_RST_BIT;
      rstb_q  <= `MB_RST_BIT;
    end else if (in_load) begin
      wdata_q <= write_data;
      waddr_q <= write_addr;
      raddr_q <= read_addr;
      wstb_q  <= wstb_raw;
      rstb_q  <= rstb_raw;
    end
  end

  reg  [DATA_W-1:0] wdata_eff;
  reg  [ADDR_W-1:0] waddr_eff;
  reg  [ADDR_W-1:0] raddr_sel;
  reg               wstb_eff;
  reg               rstb_eff;

  // Each bypass bit picks the raw input or its registered copy on its own;
  // a registered signal is the one captured at the last port tick with in_clk_en high.
  always @* begin
    if (reg_bypass[`MB_BYP_WDATA]) begin
      wdata_eff = write_data;
    end else begin
      wdata_eff = wdata_q;
    end
    if (reg_bypass[`MB_BYP_WADDR]) begin
      waddr_eff = write_addr;
    end else begin
      waddr_eff = waddr_q;
    end
    if (reg_bypass[`MB_BYP_RADDR]) begin
      raddr_sel = read_addr;
    end else begin
      raddr_sel = raddr_q;
    end
    if (reg_bypass[`MB_BYP_WSTB]) begin
      wstb_eff = wstb_raw;
    end else begin
      wstb_eff = wstb_q;
    end
    if (reg_bypass[`MB_BYP_RSTB]) begin
      rstb_eff = rstb_raw;
    end else begin
      rstb_eff = rstb_q;
    end
  end

  // --------------------------------------------------------------------------
  // Port arbitration
  // --------------------------------------------------------------------------
  // Single-port mode shares the write address for both kinds of access; if
  // both strobes are seen together the write is done and the read dropped.
  reg  [ADDR_W-1:0] raddr_eff;
  reg               single;
  reg               both_req;
  reg               do_write;
  reg               do_read;

  always @* begin
    single = (port_mode == `MB_MODE_SINGLE);
    if (single) begin
      raddr_eff = waddr_eff;
    end else begin
      raddr_eff = raddr_sel;
    end
    both_req = wstb_eff & rstb_eff;
    do_write = in_tick & wstb_eff;
    do_read  = in_tick & rstb_eff & ~(single & wstb_eff);
  end

  // --------------------------------------------------------------------------
  // Storage array
  // --------------------------------------------------------------------------
  // The array has no clear; only its port registers do.
  reg  [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  reg  [DATA_W-1:0] rd_word_q;

  always @(posedge clk) begin
    if (do_write) begin
      mem[waddr_eff] <= wdata_eff;
    end
  end

  // In split mode a read and a write to one address in the same tick return the old word.
  always @(posedge clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      rd_word_q <= {DATA_W{`MB_RST_BIT}};
    end else if (do_read) begin
      rd_word_q <= mem[raddr_eff];
    end
  end

  // --------------------------------------------------------------------------
  // Output-side register
  // --------------------------------------------------------------------------
  reg  [DATA_W-1:0] rdata_q;

  always @(posedge clk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      rdata_q <= {DATA_W{`MB_RST_BIT}};
    end else if (out_load) begin
      rdata_q <= rd_word_q;
    end
  end

  assign read_data = reg_bypass[`MB_BYP_RDATA] ? rd_word_q : rdata_q;

  // --------------------------------------------------------------------------
  // Conflict report
  // --------------------------------------------------------------------------
  // Flags one cycle after a single-port tick in which both strobes were seen.
  reg  conflict_q;

  always @(posedge clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      conflict_q <= `MB_RST_BIT;
    end else begin
      conflict_q <= in_tick & single & both_req;
    end
  end

  assign access_conflict = conflict_q;

endmodule

`default_nettype wire

// File: dv/memory_block_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "memory_block_defs.vh"
// ----------------------------------------------------------------------------
// Port-level checks
// ----------------------------------------------------------------------------
module memory_block_monitor #(
  parameter DATA_W     = 8,
  parameter NUM_GLOBAL = 4
) (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  port_mode,
  input wire logic [`MB_BYP_W-1:0]  reg_bypass,
  input wire logic [NUM_GLOBAL-1:0] global_from_logic,
  input wire logic [1:0]            in_clk_src,
  input wire logic                  wstb_src,
  input wire logic                  rstb_src,
  input wire logic [NUM_GLOBAL-1:0] dedicated_in_pin,
  input wire logic [NUM_GLOBAL-1:0] global_logic_drive,
  input wire logic                  in_clk_local,
  input wire logic                  out_clk_en,
  input wire logic                  in_clr_local,
  input wire logic                  out_clr_local,
  input wire logic                  write_strobe_local,
  input wire logic                  read_strobe_local,
  input wire logic [DATA_W-1:0]     read_data,
  input wire logic [NUM_GLOBAL-1:0] global_net,
  input wire logic                  access_conflict
);
  // Only the all-local, unregistered-strobe setup lets a tick be seen at the ports.
  wire loc = in_clk_src == `MB_CSRC_LOCAL && wstb_src == `MB_SSRC_LOCAL &&
             rstb_src == `MB_SSRC_LOCAL && reg_bypass[5:4] == 2'b11;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_conf_pulse;
    access_conflict |=> !access_conflict;
  endproperty
  a_conf_pulse: assert property (p_conf_pulse)
    else $error("conflict flag held too long");
  property p_conf_single;
    access_conflict |-> port_mode == `MB_MODE_SINGLE;
  endproperty
  a_conf_single: assert property (p_conf_single)
    else $error("conflict flag outside single-port mode");
  property p_conf_raise;
    port_mode == `MB_MODE_SINGLE && loc && $rose(in_clk_local) && write_strobe_local &&
      !in_clr_local && !$past(in_clr_local) |=> access_conflict == $past(read_strobe_local);
  endproperty
  a_conf_raise: assert property (p_conf_raise)
    else $error("conflict flag wrong after a single-port tick");
  property p_global_logic;
    ((global_net ^ global_logic_drive) & global_from_logic) == '0;
  endproperty
  a_global_logic: assert property (p_global_logic)
    else $error("global net not following fabric drive");
  property p_global_pin;
    !global_from_logic[3] && $past(resetn, 2) |-> global_net[3] == $past(dedicated_in_pin[3], 2);
  endproperty
  a_global_pin: assert property (p_global_pin)
    else $error("global net not following its pin");
  property p_rd_hold;
    reg_bypass[1] && loc && !($rose(in_clk_local) && read_strobe_local) && !in_clr_local &&
      !$past(in_clr_local) |=> $stable(read_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_out_hold;
    !reg_bypass[1] && !out_clk_en && !out_clr_local && !$past(out_clr_local) |=> $stable(read_data);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output register loaded while disabled");
  property p_out_clear;
    !reg_bypass[1] && $past(out_clr_local) |-> read_data == '0;
  endproperty
  a_out_clear: assert property (p_out_clear)
    else $error("output register not cleared");
  property p_in_clear;
    $past(in_clr_local) |-> !access_conflict && (!reg_bypass[1] || read_data == '0);
  endproperty
  a_in_clear: assert property (p_in_clear)
    else $error("input side not cleared");
endmodule

bind embedded_memory_block memory_block_monitor #(
  .DATA_W     (DATA_W),
  .NUM_GLOBAL (NUM_GLOBAL)
) u_mon (.*);
`default_nettype wire

// File: dv/fabric_clock_driver.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Fabric-side output port clock
// ----------------------------------------------------------------------------
// The clock stands low while idle, so no stray tick reaches the memory block.
module fabric_clock_driver #(
  parameter HALF = 2
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic run,
  output var logic  port_clk
);
  int cnt_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
      port_clk <= 1'b0;
    end else if (!run) begin
      cnt_q <= 0;
      port_clk <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      port_clk <= ~port_clk;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_dual_clock_memory_block.sv
`timescale 1ns/10ps
`default_nettype none
`include "memory_block_defs.vh"
module tb_dual_clock_memory_block;
  logic       clk = 0, resetn = 0, port_mode, in_clk_local, in_clk_en, out_clk_en, oclk_run;
  logic       in_clr_local, out_clr_local, write_strobe_local, read_strobe_local, wstb_src;
  logic       rstb_src, in_clr_global_en, out_clr_global_en, out_clk_local, access_conflict;
  logic [5:0] reg_bypass, write_addr, read_addr;
  logic [1:0] in_clk_src, out_clk_src, in_clk_idx, out_clk_idx, wstb_idx, rstb_idx, clr_global_idx;
  logic [3:0] global_from_logic, dedicated_in_pin, dedicated_clk_pin, global_logic_drive, global_net;
  logic [7:0] write_data, read_data;
  int         errors = 0, tests_run = 0;

  always #10 clk = ~clk;
  embedded_memory_block dut (.*);
  fabric_clock_driver #(.HALF(2)) u_oclk (.clk(clk), .resetn(resetn), .run(oclk_run),
                                          .port_clk(out_clk_local));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One port clock tick: high for one cycle, low for one, then let the answer land.
  task tick(input logic we, input logic gw, input logic re, input logic [5:0] wa,
            input logic [5:0] ra, input logic [7:0] wd);
    @(posedge clk);
    in_clk_local <= 1'b1;
    dedicated_clk_pin <= 4'h1;
    global_logic_drive[1:0] <= {gw, 1'b1};
    {write_strobe_local, read_strobe_local, write_addr, read_addr, write_data} <= {we, re, wa, ra, wd};
    @(posedge clk);
    {in_clk_local, write_strobe_local, read_strobe_local} <= 3'b000;
    dedicated_clk_pin <= 4'h0;
    global_logic_drive[1:0] <= 2'b00;
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_split;
    tick(1, 1, 0, 6'h05, 6'h00, 8'h3C);
    tick(1, 1, 1, 6'h06, 6'h05, 8'hA5);
    check(read_data, 8'h3C);
    tick(1, 1, 1, 6'h05, 6'h05, 8'h77);
    check(read_data, 8'h3C);
    tick(0, 0, 1, 6'h00, 6'h05, 8'h00);
    check(read_data, 8'h77);
    in_clr_local <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(read_data, 8'h00);
    in_clr_local <= 1'b0;
  endtask
  task t_conflict;
    port_mode <= `MB_MODE_SINGLE;
    tick(1, 1, 1, 6'h09, 6'h00, 8'h5A);
    check(read_data, 8'h00);
    tick(0, 0, 1, 6'h09, 6'h00, 8'h00);
    check(read_data, 8'h5A);
    port_mode <= `MB_MODE_SPLIT;
  endtask
  task t_regs;
    reg_bypass <= 6'h3B;
    tick(0, 0, 1, 6'h00, 6'h06, 8'h00);
    tick(0, 0, 1, 6'h00, 6'h09, 8'h00);
    check(read_data, 8'hA5);
    reg_bypass <= 6'h3F;
  endtask
  task t_global;
    tick(1, 1, 0, 6'h10, 6'h00, 8'h01);
    {in_clk_src, wstb_src} <= {`MB_CSRC_GLOBAL, `MB_SSRC_GLOBAL};
    tick(1, 0, 0, 6'h10, 6'h00, 8'hEE);
    tick(0, 1, 0, 6'h11, 6'h00, 8'h22);
    {in_clk_src, wstb_src} <= {`MB_CSRC_LOCAL, `MB_SSRC_LOCAL};
    tick(0, 0, 1, 6'h00, 6'h10, 8'h00);
    check(read_data, 8'h01);
    tick(0, 0, 1, 6'h00, 6'h11, 8'h00);
    check(read_data, 8'h22);
    dedicated_in_pin <= 4'h8;
    repeat (3) @(posedge clk);
    #1;
    check({4'h0, global_net}, 8'h08);
  endtask
  task t_dedic;
    in_clk_src <= `MB_CSRC_DEDIC;
    @(posedge clk);
    {dedicated_clk_pin, write_strobe_local, write_addr, write_data} <= {4'h1, 1'b1, 6'h12, 8'h6B};
    repeat (4) @(posedge clk);
    {dedicated_clk_pin, write_strobe_local} <= {4'h0, 1'b0};
    repeat (4) @(posedge clk);
    in_clk_src <= `MB_CSRC_LOCAL;
    tick(0, 0, 1, 6'h00, 6'h12, 8'h00);
    check(read_data, 8'h6B);
    {reg_bypass, in_clk_en} <= {6'h3E, 1'b0};
    tick(1, 1, 0, 6'h13, 6'h00, 8'h99);
    {reg_bypass, in_clk_en} <= {6'h3F, 1'b1};
    tick(0, 0, 1, 6'h00, 6'h13, 8'h00);
    check(read_data, 8'h00);
  endtask
  task t_outreg;
    {reg_bypass, oclk_run} <= {6'h3D, 1'b1};
    tick(0, 0, 1, 6'h00, 6'h11, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    check(read_data, 8'h00);
    out_clk_en <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(read_data, 8'h22);
    out_clr_local <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(read_data, 8'h00);
    out_clr_local <= 1'b0;
    repeat (8) @(posedge clk);
    {out_clr_global_en, global_logic_drive[2]} <= 2'b11;
    repeat (2) @(posedge clk);
    #1;
    check(read_data, 8'h00);
  endtask

  initial begin
    {port_mode, reg_bypass, global_from_logic} = {`MB_MODE_SPLIT, 6'h3F, 4'h7};
    {in_clk_src, out_clk_src, wstb_src, rstb_src} = {`MB_CSRC_LOCAL, `MB_CSRC_LOCAL, 2'b00};
    {in_clk_idx, out_clk_idx, wstb_idx, rstb_idx, clr_global_idx} = 10'b00_00_01_00_10;
    {in_clr_global_en, out_clr_global_en, in_clk_en, out_clk_en, oclk_run} = 5'b00100;
    {dedicated_in_pin, dedicated_clk_pin, global_logic_drive} = 12'h000;
    {in_clk_local, in_clr_local, out_clr_local, write_strobe_local, read_strobe_local} = 5'b0;
    {write_data, write_addr, read_addr} = 20'h0_0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_split;
    t_conflict;
    t_regs;
    t_global;
    t_dedic;
    t_outreg;
    end_sim;
  end
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
